// File: design/rmss_map.vh
// Address map, field layout and scale constants of the rail monitor
// status and set-point registers.
// Assumes an 8-bit register address space and an 8-bit data path.
//
// Notes on behaviour
// - Undervoltage flags at 0x6, read clears all but those with a violation in the read cycle
// - Flag is one when input below threshold
// - Live off-threshold status at 0x7, read only
// - Off bit one while input below threshold
// - Channels 1-4 nominal: 500 mV plus 12.5 mV/step
// - Channel 5 nominal: 500 mV plus 20 mV/step
// - Channel 6 undervoltage: 500 mV plus 5 mV/step
// - Channels 6, 7 overvoltage at 0xD, 0xF
// - Nominal set points occupy 0x8 through 0xC
// - Comparisons act only while channel monitoring enabled; the off bits at 0x7 are read back unmasked by the enable
// - Channel 1-5 thresholds are nominal times percent code factors
// - Channel 7 undervoltage set point at 0x10
`ifndef RMSS_MAP_VH
`define RMSS_MAP_VH

`define RMSS_ADDR_W        8
`define RMSS_DATA_W        8
`define RMSS_CHANNELS      7

`define RMSS_OFS_UV_FLAGS  8'h06
`define RMSS_OFS_OFF_LIVE  8'h07
`define RMSS_OFS_NOM1      8'h08
`define RMSS_OFS_NOM2      8'h09
`define RMSS_OFS_NOM3      8'h0a
`define RMSS_OFS_NOM4      8'h0b
`define RMSS_OFS_NOM5      8'h0c
`define RMSS_OFS_OV6       8'h0d
`define RMSS_OFS_UV6       8'h0e
`define RMSS_OFS_OV7       8'h0f
`define RMSS_OFS_UV7       8'h10

// Set-point slots, counted from the channel 1 nominal offset
`define RMSS_SP_FIRST      8'h08
`define RMSS_SP_COUNT      9
`define RMSS_SP_IDX_W      4
`define RMSS_SP_NOM5       4
`define RMSS_SP_OV6        5
`define RMSS_SP_UV6        6
`define RMSS_SP_OV7        7
`define RMSS_SP_UV7        8

// Reset values (set points held until the nonvolatile store has loaded) and the read value of unmapped addresses
`define RMSS_SP_RESET      8'h00
`define RMSS_FLAGS_RESET   7'h00
`define RMSS_RDATA_RESET   8'h00
`define RMSS_UNMAPPED_RD   8'h00

// Levels in half-millivolt units: base plus step times code
`define RMSS_LVL_BASE      14'h03e8
`define RMSS_STEP_NOM14    14'h0019
`define RMSS_STEP_NOM5     14'h0028
`define RMSS_STEP_ABS      14'h000a
`define RMSS_LVL_W         14

// Percent factors in tenths of a percent
`define RMSS_OV_PCT_BASE   11'h401
`define RMSS_UV_PCT_BASE   11'h3cf
`define RMSS_PCT_STEP      11'h005
`define RMSS_PCT_W         11
`define RMSS_THR_W         24

`endif

// File: design/rmss_uv_latch.v
// Sticky undervoltage flags, one per channel, cleared by a read.
// Assumes comparator levels are synchronous to clk_sys.
`timescale 1ns/100ps
`include "rmss_map.vh"

module rmss_uv_latch (
    input  wire       clk_sys,
    input  wire       rst_b,
    input  wire [6:0] uv_below,
    input  wire [6:0] mon_enable,
    input  wire       clear,
    output wire [6:0] flags
);

    reg  [6:0] flags_q;
    reg  [6:0] flags_d;
    wire [6:0] violation;

    assign violation = uv_below & mon_enable;
    assign flags     = flags_q;

    // A violation in the clearing cycle keeps its flag set
    always @* begin
        flags_d = flags_q;
        if (clear) begin
            flags_d = 7'h00;
        end
        flags_d = flags_d | violation;
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            flags_q <= `RMSS_FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

endmodule

// File: design/rmss_thresh.v
// Overvoltage and undervoltage thresholds of one percent-based channel.
// Result unit: half millivolt times tenth of a percent (0.5 uV).
// Assumes the analog side consumes the registered results.
`timescale 1ns/100ps
`include "rmss_map.vh"

module rmss_thresh #(
    parameter [13:0] STEP = `RMSS_STEP_NOM14
) (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire [7:0]  nominal_code,
    input  wire [3:0]  over_code,
    input  wire [3:0]  under_code,
    output reg  [23:0] over_thr_q,
    output reg  [23:0] under_thr_q,
    output reg  [13:0] level_q
);

    wire [21:0] step_prod;
    wire [13:0] level_d;
    wire [10:0] ov_pct;
    wire [10:0] uv_pct;
    wire [24:0] ov_prod;
    wire [24:0] uv_prod;

    assign step_prod = STEP * nominal_code;
    assign level_d   = `RMSS_LVL_BASE + step_prod[13:0];
    assign ov_pct    = `RMSS_OV_PCT_BASE + `RMSS_PCT_STEP * {7'h00, over_code};
    assign uv_pct    = `RMSS_UV_PCT_BASE - `RMSS_PCT_STEP * {7'h00, under_code};
    assign ov_prod   = level_d * ov_pct;
    assign uv_prod   = level_d * uv_pct;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            over_thr_q  <= 24'h000000;
            under_thr_q <= 24'h000000;
            level_q     <= 14'h0000;
        end else begin
            over_thr_q  <= ov_prod[23:0];
            under_thr_q <= uv_prod[23:0];
            level_q     <= level_d;
        end
    end

endmodule

// File: design/rmss_regs.v
// Status and set-point register bank of the seven-channel rail monitor.
// Assumes the serial management engine delivers decoded single-cycle
// read and write strobes, and a nonvolatile loader delivers set points.
`timescale 1ns/100ps
`include "rmss_map.vh"

module rmss_regs (
    input  wire        clk_sys,
    input  wire        rst_b,
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire        reg_rd,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata_q,
    output reg         reg_rvalid_q,
    input  wire        nv_load,
    input  wire [7:0]  nv_addr,
    input  wire [7:0]  nv_data,
    input  wire [6:0]  channel_monitor_enable,
    input  wire [19:0] over_threshold_percent_code,
    input  wire [19:0] under_threshold_percent_code,
    input  wire [6:0]  uv_cmp_below,
    input  wire [6:0]  off_cmp_below,
    output wire [119:0] pct_over_threshold,
    output wire [119:0] pct_under_threshold,
    output wire [69:0] nominal_rail_level,
    output reg  [13:0] ch6_over_level_q,
    output reg  [13:0] ch6_under_level_q,
    output reg  [13:0] ch7_over_level_q,
    output reg  [13:0] ch7_under_level_q,
    output wire [6:0]  comparator_enable
);

    reg  [7:0] sp_q [0:8];
    wire [6:0] uv_flags;
    wire       uv_clear;
    wire [4:0] host_hit;
    wire [4:0] nv_hit;
    reg  [7:0] rdata_d;

    // Returns {hit, index} for a set-point address
    function [4:0] rmss_sp_index;
        input [7:0] addr;
        reg   [7:0] rel;
        begin
            rel = addr - `RMSS_SP_FIRST;
            if (addr >= `RMSS_SP_FIRST && rel < `RMSS_SP_COUNT) begin
                rmss_sp_index = {1'b1, rel[3:0]};
            end else begin
                rmss_sp_index = 5'h00;
            end
        end
    endfunction

    // Level of an absolute set point in half millivolts
    function [13:0] rmss_abs_level;
        input [7:0] code;
        reg   [13:0] prod;
        begin
            prod = `RMSS_STEP_ABS * {6'h00, code};
            rmss_abs_level = `RMSS_LVL_BASE + prod;
        end
    endfunction

    assign host_hit = rmss_sp_index(reg_addr);
    assign nv_hit   = rmss_sp_index(nv_addr);
    assign uv_clear = reg_rd && (reg_addr == `RMSS_OFS_UV_FLAGS);
    assign comparator_enable = channel_monitor_enable;

    genvar i;
    generate
        for (i = 0; i < `RMSS_SP_COUNT; i = i + 1) begin : g_sp
            // Nonvolatile reload wins over a host write in the same cycle
            always @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    sp_q[i] <= `RMSS_SP_RESET;
                end else if (nv_load && nv_hit[4] && nv_hit[3:0] == i) begin
                    sp_q[i] <= nv_data;
                end else if (reg_wr && host_hit[4] &&
                             host_hit[3:0] == i) begin
                    sp_q[i] <= reg_wdata;
                end
            end
        end
        for (i = 0; i < 5; i = i + 1) begin : g_thr
            rmss_thresh #(
                .STEP ((i == 4) ? `RMSS_STEP_NOM5 : `RMSS_STEP_NOM14)
            ) u_thresh (
                .clk_sys      (clk_sys),
                .rst_b        (rst_b),
                .nominal_code (sp_q[i]),
                .over_code    (over_threshold_percent_code[4*i+3:4*i]),
                .under_code   (under_threshold_percent_code[4*i+3:4*i]),
                .over_thr_q   (pct_over_threshold[24*i+23:24*i]),
                .under_thr_q  (pct_under_threshold[24*i+23:24*i]),
                .level_q      (nominal_rail_level[14*i+13:14*i])
            );
        end
    endgenerate

    rmss_uv_latch u_uv_latch (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .uv_below   (uv_cmp_below),
        .mon_enable (channel_monitor_enable),
        .clear      (uv_clear),
        .flags      (uv_flags)
    );

    // Absolute thresholds of channels 6 and 7
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ch6_over_level_q  <= 14'h0000;
            ch6_under_level_q <= 14'h0000;
            ch7_over_level_q  <= 14'h0000;
            ch7_under_level_q <= 14'h0000;
        end else begin
            ch6_over_level_q  <= rmss_abs_level(sp_q[`RMSS_SP_OV6]);
            ch6_under_level_q <= rmss_abs_level(sp_q[`RMSS_SP_UV6]);
            ch7_over_level_q  <= rmss_abs_level(sp_q[`RMSS_SP_OV7]);
            ch7_under_level_q <= rmss_abs_level(sp_q[`RMSS_SP_UV7]);
        end
    end

    // Read data: flags sampled before their clear takes effect
    always @* begin
        rdata_d = `RMSS_UNMAPPED_RD;
        if (reg_addr == `RMSS_OFS_UV_FLAGS) begin
            rdata_d = {1'b0, uv_flags};
        end else if (reg_addr == `RMSS_OFS_OFF_LIVE) begin
            rdata_d = {1'b0, off_cmp_below};
        end else if (host_hit[4]) begin
            rdata_d = sp_q[host_hit[3:0]];
        end
    end

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_q  <= `RMSS_RDATA_RESET;
            reg_rvalid_q <= 1'b0;
        end else begin
            reg_rvalid_q <= reg_rd;
            if (reg_rd) begin
                reg_rdata_q <= rdata_d;
            end
        end
    end

endmodule

// File: verif/rmss_host.sv
// Host side of the register port: read and write strobes held for n cycles.
// Assumes the bench calls its task from one process at a time.
`timescale 1ns/100ps
module rmss_host (
    input  logic       clk_sys,
    output logic [7:0] reg_addr,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [7:0] reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end

    // Strobe stays high for n cycles; released data shows its inverse
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d, input int n);
        @(negedge clk_sys);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = wr;
        reg_rd = !wr;
        repeat (n) @(negedge clk_sys);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = ~d;
    endtask
endmodule

// File: verif/rmss_chk.sv
// Checker of read answers, status bits and set-point scaling.
// Assumes a bind to rmss_regs; percent codes steady around writes.
`timescale 1ns/100ps
module rmss_chk (
    input logic          clk_sys,
    input logic          rst_b,
    input logic [7:0]    reg_addr,
    input logic          reg_wr,
    input logic          reg_rd,
    input logic [7:0]    reg_wdata,
    input logic [7:0]    reg_rdata_q,
    input logic          reg_rvalid_q,
    input logic          nv_load,
    input logic [6:0]    channel_monitor_enable,
    input logic [19:0]   over_threshold_percent_code,
    input logic [6:0]    uv_cmp_below,
    input logic [6:0]    off_cmp_below,
    input logic [119:0]  pct_over_threshold,
    input logic [13:0]   ch6_under_level_q,
    input logic [13:0]   ch7_under_level_q,
    input logic [6:0]    comparator_enable
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire rd6 = reg_rd && reg_addr == 8'h06;
    wire rd7 = reg_rd && reg_addr == 8'h07;

    chk_read_answer: assert property (reg_rd |=> reg_rvalid_q)
        else $error("read not answered");
    chk_no_spurious: assert property (!reg_rd |=> !reg_rvalid_q)
        else $error("answer without read");
    chk_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata_q))
        else $error("read data moved");
    chk_off_live: assert property (rd7 |=> reg_rdata_q ==
        {1'b0, $past(off_cmp_below)}) else $error("off bits wrong");
    chk_uv_top_bit: assert property (rd6 |=> !reg_rdata_q[7])
        else $error("unused bit set");
    chk_uv_rearm: assert property (rd6 ##1 rd6 |=> reg_rdata_q[6:0] ==
        $past(uv_cmp_below & channel_monitor_enable, 2))
        else $error("flag not re-set");
    chk_enable_pass: assert property (comparator_enable ==
        channel_monitor_enable) else $error("enable mismatch");
    chk_ch6_scale: assert property (reg_wr && reg_addr == 8'h0e &&
        !nv_load |-> ##3 ch6_under_level_q ==
        14'd1000 + 14'd10 * $past(reg_wdata, 3)) else $error("ch6 level");
    chk_ch7_scale: assert property (reg_wr && reg_addr == 8'h10 &&
        !nv_load |-> ##3 ch7_under_level_q ==
        14'd1000 + 14'd10 * $past(reg_wdata, 3)) else $error("ch7 level");
    chk_pct_scale: assert property (reg_wr && reg_addr == 8'h08 &&
        !nv_load |-> ##3 pct_over_threshold[23:0] ==
        (24'd1000 + 24'd25 * $past(reg_wdata, 3)) *
        (24'd1025 + 24'd5 * over_threshold_percent_code[3:0]))
        else $error("ch1 threshold");

    cover property (rd6 ##1 reg_rdata_q[6:0] != 7'h00);
    cover property (rd6 ##1 rd6);
    cover property (rd7);
endmodule

// File: verif/tb.sv
// Bench: loader and host traffic, comparator stimulus, queued checks.
// Assumes rmss_regs, rmss_host and rmss_chk are compiled before it.
`timescale 1ns/100ps
`define RMSS_CMP(g, e) begin checked++; if ((g) !== (e)) begin fails++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic         clk_sys = 1'b0;
    logic         rst_b = 1'b0;
    wire  [7:0]   reg_addr, reg_wdata, reg_rdata_q;
    wire          reg_wr, reg_rd, reg_rvalid_q;
    logic         nv_load;
    logic [7:0]   nv_addr, nv_data, e;
    logic [6:0]   channel_monitor_enable, uv_cmp_below, off_cmp_below, v;
    logic [19:0]  over_threshold_percent_code, under_threshold_percent_code;
    logic [7:0]   sp[0:8];
    logic [7:0]   exp_q[$];
    int           fails = 0, checked = 0, r;

    always #2.5 clk_sys = ~clk_sys;
    rmss_host rmss_host_inst (.clk_sys, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata);
    rmss_regs rmss_regs_inst (.clk_sys, .rst_b, .reg_addr, .reg_wr, .reg_rd,
        .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .nv_load, .nv_addr,
        .nv_data, .channel_monitor_enable, .over_threshold_percent_code,
        .under_threshold_percent_code, .uv_cmp_below, .off_cmp_below,
        .pct_over_threshold(), .pct_under_threshold(),
        .nominal_rail_level(), .ch6_over_level_q(), .ch6_under_level_q(),
        .ch7_over_level_q(), .ch7_under_level_q(), .comparator_enable());

    task automatic complete_run;
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        rmss_host_inst.access(1'b0, a, 8'h00, 1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        rmss_host_inst.access(1'b1, a, d, 1);
    endtask

    always @(posedge clk_sys) begin
        #1;
        if (reg_rvalid_q === 1'b1) begin
            e = exp_q.pop_front();
            `RMSS_CMP(reg_rdata_q, e)
        end
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        complete_run();
    end
    initial begin
        {nv_load, nv_addr, nv_data, uv_cmp_below, off_cmp_below} = '0;
        channel_monitor_enable = 7'h7f;
        over_threshold_percent_code = 20'h00000;
        under_threshold_percent_code = 20'h00000;
        r = $urandom(32'h54a0);
        repeat (12) @(negedge clk_sys);
        rst_b = 1'b1;
        over_threshold_percent_code = 20'($urandom);
        under_threshold_percent_code = 20'($urandom);
        for (int i = 0; i < 9; i++) begin
            @(negedge clk_sys);
            sp[i] = 8'($urandom);
            nv_load = 1'b1;
            nv_addr = 8'h08 + 8'(i);
            nv_data = sp[i];
        end
        @(negedge clk_sys) nv_load = 1'b0;
        for (int i = 0; i < 9; i++) rd(8'h08 + 8'(i), sp[i]);
        for (int i = 0; i < 9; i++) begin
            sp[i] = 8'($urandom);
            wr(8'h08 + 8'(i), sp[i]);
            rd(8'h08 + 8'(i), sp[i]);
        end
        wr(8'h06, 8'hff);
        wr(8'h07, 8'hff);
        wr(8'h11, 8'h5a);
        foreach (sp[i]) rd(8'h08 + 8'(i), sp[i]);
        rd(8'h06, 8'h00);
        rd(8'h07, 8'h00);
        rd(8'h11, 8'h00);
        rd(8'h05, 8'h00);
        for (int i = 0; i < 6; i++) begin
            v = 7'($urandom);
            @(negedge clk_sys);
            channel_monitor_enable = (i == 0) ? 7'h7f : 7'($urandom);
            off_cmp_below = 7'($urandom);
            uv_cmp_below = v;
            @(negedge clk_sys) uv_cmp_below = 7'h00;
            rd(8'h06, {1'b0, v & channel_monitor_enable});
            rd(8'h06, 8'h00);
            rd(8'h07, {1'b0, off_cmp_below});
        end
        uv_cmp_below = v;
        rd(8'h06, {1'b0, v & channel_monitor_enable});
        exp_q.push_back({1'b0, v & channel_monitor_enable});
        exp_q.push_back({1'b0, v & channel_monitor_enable});
        rmss_host_inst.access(1'b0, 8'h06, 8'h00, 2);
        uv_cmp_below = 7'h00;
        rd(8'h06, {1'b0, v & channel_monitor_enable});
        rd(8'h06, 8'h00);
        for (int k = 0; k < 50 && exp_q.size() > 0; k++) @(posedge clk_sys);
        if (exp_q.size() > 0) fails++;
        complete_run();
    end
endmodule

bind rmss_regs rmss_chk rmss_chk_inst (.clk_sys, .rst_b, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .nv_load,
    .channel_monitor_enable, .over_threshold_percent_code, .uv_cmp_below,
    .off_cmp_below, .pct_over_threshold, .ch6_under_level_q,
    .ch7_under_level_q,
    .comparator_enable);
